// File: rtl/flash_status_consts.svh
// command codes, status bit positions and reset values of the status logic
// assumes inclusion by bare name from the package; the design modules see its macros through it
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROGRAM 8'h40
`define CMD_ERASE 8'h20
`define CMD_ERASE_CONFIRM 8'hD0
`define SRD_READY_POS 7
`define SRD_ERASE_POS 5
`define SRD_PROG_POS 4
`define RST_READY 1'b1
`define RST_FAIL 1'b0
`define SRD_RSVD 8'h00
`endif

// File: rtl/flash_status_pkg.sv
// types shared by the status logic of the flash rewrite sequencer
// assumes the constants header sits in the include path
package flash_status_pkg;
`include "flash_status_consts.svh"
   // one cpu command bus cycle toward the sequencer
   typedef struct packed {
      logic wr;         // write strobe, one cycle
      logic rd;         // read strobe, one cycle
      logic even_rom;   // address is an even user rom address
      logic prot;       // addressed block is protected
      logic [15:0] data; // write data, upper byte ignored for commands
   } cmd_cycle_t;
   // command decoder state
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_prog_wait = 2'b01,
      st_erase_wait = 2'b10
   } seq_state_t;
   // flag bundle with the mirror bits
   typedef struct packed {
      logic ready;
      logic erase_fail;
      logic prog_fail;
   } flags_t;
endpackage

// File: rtl/status_byte_reg.sv
// output register holding the assembled status byte
// assumes flags come from logic on the same clock
`timescale 1ns/1ps
module status_byte_reg
   import flash_status_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire flags_t flags,
   input wire logic suspend,
   output logic [7:0] flash_status_byte
);
   ////////////////////////////////////////////////////////////////////////
   // build the byte each cycle, reserved bits stay zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flash_status_byte <= 8'h80; // ready after reset, fails cleared
      end else begin
         flash_status_byte <= `SRD_RSVD; // RQ18
         flash_status_byte[`SRD_READY_POS] <= flags.ready & ~suspend; // RQ3
         flash_status_byte[`SRD_ERASE_POS] <= flags.erase_fail; // RQ3
         flash_status_byte[`SRD_PROG_POS] <= flags.prog_fail; // RQ3
      end
   end
   // reserved bits must never show a one
   a_rsvd_zero: assert property (@(posedge clock) disable iff (!nrst)
      (flash_status_byte & 8'h4F) == 8'h00) // RQ18
      else $error("reserved status bit set");
endmodule

// File: rtl/flash_status_error_report.sv
// status and error reporting of the flash rewrite sequencer
// assumes the cpu side drives one-cycle strobes on the system clock and the
// flash core returns a done pulse with a fail level at the end of an operation
`timescale 1ns/1ps
// Summary of operation
// (RQ1) busy while auto operation runs, ready after
// (RQ2) erase suspend reports sequence status busy
// (RQ3) status byte: ready bit7, erase bit5, program bit4
// (RQ4) control register mirrors the three status bits
// (RQ5) clear status zeroes both failure flags
// (RQ6) any failure flag blocks program and erase
// (RQ7) bad command sets both failure flags
// (RQ8) erase second cycle must be confirm or read-array
// (RQ9) protected block target gives sequence error; the code gives it only while no failure flag is set
// (RQ10) erase failure sets only erase flag
// (RQ11) program failure sets only program flag
// (RQ12) read-array in second cycle aborts command
// (RQ13) read status command makes reads return status
// (RQ14) after program/erase reads return status
// (RQ15) clear status is single write of 50h
// (RQ16) read status is write of 70h
// (RQ17) status read mode holds until read-array
// (RQ18) reserved bits zero, reset ready and cleared
module flash_status_error_report
   import flash_status_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire cmd_cycle_t cmd,
   input wire logic erase_write_mode_zero,
   input wire logic suspend,
   input wire logic op_done,
   input wire logic op_fail,
   input wire logic [15:0] array_data,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic start_prog,
   output logic start_erase,
   output logic [15:0] prog_data,
   output logic [7:0] flash_ctl_reg_zero,
   output logic [7:0] flash_status_byte
);
   seq_state_t state; // two-cycle command tracking
   flags_t flags; // ready and failure flags
   logic busy_erase; // running operation is an erase
   logic status_mode; // reads return status byte
   logic [7:0] code; // low command byte
   logic wr_ok; // command write to even rom address
   logic blocked; // a failure flag is set
   logic seq_err; // command sequence error this cycle
   logic susp_q; // suspend aligned to the byte register
   assign code = cmd.data[7:0]; // RQ15
   assign wr_ok = cmd.wr & cmd.even_rom;
   assign blocked = flags.erase_fail | flags.prog_fail;
   ////////////////////////////////////////////////////////////////////////
   // sequence error: wrong erase confirm, protected target, unknown code
   always_comb begin
      seq_err = 1'b0;
      if (wr_ok && flags.ready) begin
         case (state)
            st_erase_wait: begin
               if (code != `CMD_ERASE_CONFIRM && code != `CMD_READ_ARRAY)
                  seq_err = 1'b1; // RQ8
               else if (code == `CMD_ERASE_CONFIRM && cmd.prot && !blocked)
                  seq_err = 1'b1; // RQ9
            end
            st_prog_wait: begin
               if (cmd.prot && !blocked && code != `CMD_READ_ARRAY)
                  seq_err = 1'b1; // RQ9
            end
            st_idle: begin
               case (code)
                  `CMD_READ_ARRAY, `CMD_READ_STATUS, `CMD_CLEAR_STATUS,
                  `CMD_PROGRAM, `CMD_ERASE: seq_err = 1'b0;
                  default: seq_err = 1'b1; // RQ7
               endcase
            end
            default: seq_err = 1'b0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // command state and operation start
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= st_idle;
         start_prog <= 1'b0;
         start_erase <= 1'b0;
         prog_data <= 16'h0000;
      end else begin
         start_prog <= 1'b0;
         start_erase <= 1'b0;
         // writes while busy are ignored, the core owns the array then
         if (wr_ok && flags.ready) begin
            case (state)
               st_idle: begin
                  if (code == `CMD_PROGRAM)
                     state <= st_prog_wait;
                  else if (code == `CMD_ERASE)
                     state <= st_erase_wait;
               end
               st_prog_wait: begin
                  state <= st_idle;
                  // a read-array code here would be ambiguous with data;
                  // it is taken as an abort, the safe reading
                  if (code != `CMD_READ_ARRAY && !blocked && !seq_err) begin
                     start_prog <= 1'b1; // RQ6
                     prog_data <= cmd.data;
                  end
               end
               st_erase_wait: begin
                  state <= st_idle; // RQ12
                  if (code == `CMD_ERASE_CONFIRM && !blocked && !seq_err)
                     start_erase <= 1'b1; // RQ6
               end
               default: state <= st_idle;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // ready flag and kind of running operation
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flags.ready <= `RST_READY; // RQ18
         busy_erase <= 1'b0;
      end else if (start_prog || start_erase) begin
         flags.ready <= 1'b0; // RQ1
         busy_erase <= start_erase;
      end else if (op_done && !flags.ready) begin
         flags.ready <= 1'b1; // RQ1
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // failure flags; a setting event wins over a clear in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flags.erase_fail <= `RST_FAIL; // RQ18
         flags.prog_fail <= `RST_FAIL;
      end else if (seq_err) begin
         flags.erase_fail <= 1'b1; // RQ7
         flags.prog_fail <= 1'b1;
      end else if (op_done && !flags.ready && op_fail) begin
         if (busy_erase)
            flags.erase_fail <= 1'b1; // RQ10
         else
            flags.prog_fail <= 1'b1; // RQ11
      end else if (wr_ok && flags.ready && state == st_idle &&
                   code == `CMD_CLEAR_STATUS) begin
         flags.erase_fail <= 1'b0; // RQ5
         flags.prog_fail <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // read status mode, left only by read-array
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_mode <= 1'b0;
      end else if (wr_ok && flags.ready && erase_write_mode_zero) begin
         if (code == `CMD_READ_ARRAY)
            status_mode <= 1'b0; // RQ17
         else if (state == st_idle && code == `CMD_READ_STATUS)
            status_mode <= 1'b1; // RQ16
         else if (state != st_idle)
            status_mode <= 1'b1; // RQ14
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // cpu read data: status byte on even rom address in status mode
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= cmd.rd;
         if (cmd.rd && cmd.even_rom && status_mode)
            rd_data <= {8'h00, flash_status_byte}; // RQ13
         else if (cmd.rd)
            rd_data <= array_data;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // control register mirror, same timing as the status byte
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flash_ctl_reg_zero <= 8'h01;
         susp_q <= 1'b0;
      end else begin
         susp_q <= suspend;
         flash_ctl_reg_zero <= {flags.erase_fail, flags.prog_fail, 5'h00,
                                flags.ready & ~suspend}; // RQ4 RQ2
      end
   end
   status_byte_reg u_status (
      .clock(clock),
      .nrst(nrst),
      .flags(flags),
      .suspend(suspend),
      .flash_status_byte(flash_status_byte)
   );
   ////////////////////////////////////////////////////////////////////////
   a_mirror_match: assert property (@(posedge clock) disable iff (!nrst)
      flash_ctl_reg_zero[0] == flash_status_byte[7] &&
      flash_ctl_reg_zero[7] == flash_status_byte[5] &&
      flash_ctl_reg_zero[6] == flash_status_byte[4]) // RQ4
      else $error("mirror differs from status byte");
   a_busy_start: assert property (@(posedge clock) disable iff (!nrst)
      (start_prog || start_erase) |=> !flags.ready) // RQ1
      else $error("not busy after start");
   a_suspend_busy: assert property (@(posedge clock) disable iff (!nrst)
      suspend |=> !flash_status_byte[7]) // RQ2
      else $error("ready shown in suspend");
   a_block_start: assert property (@(posedge clock) disable iff (!nrst)
      blocked |=> !(start_prog || start_erase)) // RQ6
      else $error("start while failure flag set");
   a_seq_err_both: assert property (@(posedge clock) disable iff (!nrst)
      seq_err |=> flags.erase_fail && flags.prog_fail) // RQ7
      else $error("sequence error not flagged");
   a_clear_fail: assert property (@(posedge clock) disable iff (!nrst)
      (wr_ok && flags.ready && state == st_idle &&
       code == `CMD_CLEAR_STATUS) |=> !flags.erase_fail && !flags.prog_fail)
      // RQ5
      else $error("clear status failed");
   a_erase_fail: assert property (@(posedge clock) disable iff (!nrst)
      (op_done && !flags.ready && op_fail && busy_erase && !seq_err)
      |=> flags.erase_fail && flags.ready) // RQ10
      else $error("erase failure not recorded");
   a_abort_array: assert property (@(posedge clock) disable iff (!nrst)
      (wr_ok && flags.ready && state == st_erase_wait &&
       code == `CMD_READ_ARRAY) |=> state == st_idle && !start_erase) // RQ12
      else $error("read-array did not abort");
   a_status_read: assert property (@(posedge clock) disable iff (!nrst)
      (cmd.rd && cmd.even_rom && status_mode) |=>
      rd_data[7:0] == $past(flash_status_byte)) // RQ13
      else $error("status byte not returned");
   c_prog: cover property (@(posedge clock) disable iff (!nrst) start_prog);
   c_erase: cover property (@(posedge clock) disable iff (!nrst)
      start_erase ##[1:50] op_done);
   c_seq_err: cover property (@(posedge clock) disable iff (!nrst) seq_err);
endmodule

// File: verification/flash_core_model.sv
// flash core model: answers each start pulse with a done pulse
// assumes one clock shared with the status block
`timescale 1ns/1ps
module flash_core_model #(
   parameter int LAT = 6
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic start_prog,
   input wire logic start_erase,
   input wire logic fail_req,
   output logic op_done,
   output logic op_fail
);
   logic [7:0] cnt; // cycles left in the running operation
   // countdown to done; fail level only means something with done,
   // so it toggles otherwise and a design that samples it early is seen
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= 8'h00;
         op_done <= 1'b0;
         op_fail <= 1'b0;
      end else begin
         op_done <= (cnt == 8'h01);
         op_fail <= (cnt == 8'h01) ? fail_req : ~op_fail;
         if (start_prog || start_erase) begin
            cnt <= LAT[7:0];
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// File: verification/testbench.sv
// self-checking bench for the flash status and error reporting block
// assumes the core model above answers the block's start pulses
`timescale 1ns/1ps
module testbench
   import flash_status_pkg::*;
;
   logic clock, nrst, suspend, fail_req, rd_valid, start_prog, start_erase;
   logic op_done, op_fail;
   cmd_cycle_t cmd; // cpu bus cycle toward the block
   logic [15:0] rd_data, prog_data;
   logic [7:0] ctl, sb; // control mirror and status byte
   int n_mismatch, cmp_count, cycles;
   localparam logic [15:0] ARR = 16'h5A3C; // array read data, fixed
   flash_status_error_report dut (.clock(clock), .nrst(nrst), .cmd(cmd),
      .erase_write_mode_zero(1'b1), .suspend(suspend), .op_done(op_done),
      .op_fail(op_fail), .array_data(ARR), .rd_data(rd_data),
      .rd_valid(rd_valid), .start_prog(start_prog),
      .start_erase(start_erase), .prog_data(prog_data),
      .flash_ctl_reg_zero(ctl), .flash_status_byte(sb));
   flash_core_model core (.clock(clock), .nrst(nrst),
      .start_prog(start_prog), .start_erase(start_erase),
      .fail_req(fail_req), .op_done(op_done), .op_fail(op_fail));
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one write cycle, strobe for one edge only
   task automatic wr(input logic [15:0] d, input logic p);
      @(posedge clock);
      cmd <= '{wr: 1'b1, rd: 1'b0, even_rom: 1'b1, prot: p, data: d};
      @(posedge clock);
      cmd <= '0;
   endtask
   // one read cycle; answer stands the cycle after the strobe
   task automatic rd(input logic [15:0] exp);
      @(posedge clock);
      cmd <= '{wr: 1'b0, rd: 1'b1, even_rom: 1'b1, prot: 1'b0, data: 0};
      @(posedge clock);
      cmd <= '0;
      #1;
      chk({15'h0000, rd_valid}, 16'h0001);
      chk(rd_data, exp);
   endtask
   // flags one edge, status byte a further edge after the cause
   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic run(input logic [15:0] c1, c2, input logic p, f);
      @(posedge clock);
      fail_req <= f;
      wr(c1, p);
      wr(c2, p);
      settle();
   endtask
   task automatic wait_ready;
      for (int i = 0; i < 50 && sb[7] !== 1'b1; i++) @(posedge clock);
      settle();
   endtask
   task automatic clr;
      wr(16'hA550, 1'b0); // upper byte must be ignored
      settle();
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_erase;
      run(16'h0020, 16'h00D0, 1'b0, 1'b0);
      chk({8'h00, sb}, 16'h0000);
      wait_ready();
      chk({8'h00, sb}, 16'h0080);
      rd(16'h0080);
      $display("erase ok done");
   endtask
   task automatic t_fails;
      run(16'h0020, 16'h00D0, 1'b0, 1'b1);
      wait_ready();
      chk({8'h00, sb}, 16'h00A0);
      chk({8'h00, ctl}, 16'h0081);
      run(16'h0040, 16'h1234, 1'b0, 1'b0);
      chk({8'h00, sb}, 16'h00A0);
      clr();
      chk({8'h00, sb}, 16'h0080);
      chk({8'h00, ctl}, 16'h0001);
      run(16'h0040, 16'hBEEF, 1'b0, 1'b1);
      chk(prog_data, 16'hBEEF);
      wait_ready();
      chk({8'h00, sb}, 16'h0090);
      chk({8'h00, ctl}, 16'h0041);
      clr();
      $display("fail flags done");
   endtask
   task automatic t_seq_err;
      logic [15:0] tab [4][2];
      tab = '{'{16'h0020, 16'h0040}, '{16'h0020, 16'h00D0},
         '{16'h0040, 16'h1234}, '{16'h0033, 16'h0033}};
      for (int i = 0; i < 4; i++) begin
         if (i < 3) run(tab[i][0], tab[i][1], i != 0, 1'b0);
         else begin
            wr(tab[i][0], 1'b0);
            settle();
         end
         wait_ready();
         chk({8'h00, sb}, 16'h00B0);
         chk({8'h00, ctl}, 16'h00C1);
         clr();
      end
      $display("sequence errors done");
   endtask
   task automatic t_modes;
      run(16'h0020, 16'h00FF, 1'b0, 1'b0);
      chk({8'h00, sb}, 16'h0080);
      rd(ARR);
      wr(16'h0070, 1'b0);
      settle();
      rd(16'h0080);
      rd(16'h0080);
      rd(16'h0080);
      wr(16'h00FF, 1'b0);
      settle();
      rd(ARR);
      @(posedge clock);
      suspend <= 1'b1;
      settle();
      chk({8'h00, sb}, 16'h0000);
      @(posedge clock);
      suspend <= 1'b0;
      settle();
      chk({8'h00, sb}, 16'h0080);
      $display("modes done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      nrst = 1'b0;
      cmd = '0;
      suspend = 1'b0;
      fail_req = 1'b0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      #1;
      chk({8'h00, sb}, 16'h0080);
      chk({8'h00, ctl}, 16'h0001);
      t_erase();
      t_fails();
      t_seq_err();
      t_modes();
      end_of_test();
   end
endmodule
